// file: logic/irsc_defs.svh
`ifndef IRSC_DEFS_SVH
`define IRSC_DEFS_SVH
// Register offsets (8-bit data bus, 13-bit address)
`define IRSC_ADDR_CORE_TMR  13'h0008
`define IRSC_ADDR_EXT_CTL   13'h000d
`define IRSC_ADDR_PT_STAT   13'h0013
`define IRSC_ADDR_PT_CTL    13'h0012
`define IRSC_ADDR_WDOG      13'h1ff0
`define IRSC_ADDR_CPUCTL    13'h0007
`define IRSC_ADDR_STATUS    13'h001f
// Vector addresses
`define IRSC_VEC_EXT        13'h1ffa
`define IRSC_VEC_RESET      13'h1ffe
// Core timer status/control bits
`define IRSC_CT_OVF_FLAG    7
`define IRSC_CT_PER_FLAG    6
`define IRSC_CT_OVF_EN      5
`define IRSC_CT_PER_EN      4
`define IRSC_CT_OVF_CLR     3
`define IRSC_CT_PER_CLR     2
// External interrupt status/control bits
`define IRSC_IS_EXT_EN      7
`define IRSC_IS_OSC_HIGH    6
`define IRSC_IS_OSC_LOW     5
`define IRSC_IS_PEND        3
`define IRSC_IS_REQ_CLR     1
// Programmable timer flags and enables (same positions in both registers)
`define IRSC_PT_CAPTURE     7
`define IRSC_PT_COMPARE     6
`define IRSC_PT_OVERFLOW    5
// Watchdog register bit
`define IRSC_WD_CLEAR       0
// CPU control register bits (write strobes)
`define IRSC_CPU_UNMASK     0
`define IRSC_CPU_RET_INT    1
`define IRSC_CPU_STOP       2
`define IRSC_CPU_VECFETCH   3
// Reset values
`define IRSC_EXT_CTL_RST    8'h40
// Timing
`define IRSC_BUS_NS         100
`define IRSC_PIN_PULSE      3
`define IRSC_STAB_SHORT     16
`define IRSC_STAB_LONG      4064
`define IRSC_WDOG_TIMEOUT   65536
`endif

// file: logic/irsc_pkg.sv
`default_nettype none
package irsc_pkg;
    typedef enum logic [1:0]
    {
        IRSC_RUN  = 2'b00,
        IRSC_STOP = 2'b01,
        IRSC_STAB = 2'b10
    } irsc_mode_t;
    typedef logic [7:0] irsc_byte_t;
endpackage
`default_nettype wire

// file: logic/irsc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree
module irsc_sync
    import irsc_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // Data
    input  wire logic async_in,
    output var  logic sync_out
);
    logic [2:0] sh_r;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            sh_r <= 3'h0;
        else
            sh_r <= {sh_r[1:0], async_in};
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            sync_out <= 1'b0;
        else if (sh_r[1] == sh_r[2])
            sync_out <= sh_r[2];
    end
endmodule
`default_nettype wire

// file: logic/irsc_pin_pulse.sv
`timescale 1ns/1ns
`default_nettype none
// Stretches a one-cycle request into a fixed-length reset pin pulldown
module irsc_pin_pulse
    import irsc_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // Control
    input  wire logic fire,
    output var  logic pull_oe
);
    `include "irsc_defs.svh"
    logic [2:0] cnt_r;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            cnt_r <= 3'h0;
        else if (fire && cnt_r == 3'h0)
            cnt_r <= 3'(`IRSC_PIN_PULSE);
        else if (cnt_r != 3'h0)
            cnt_r <= cnt_r - 3'h1;
    end

    // Registered so the pin sees no glitch
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            pull_oe <= 1'b0;
        else
            pull_oe <= (fire && cnt_r == 3'h0) || cnt_r > 3'h1;
    end
endmodule
`default_nettype wire

// file: logic/irsc_ctrl.sv
// Operation
// RULE1: Unmasked request: stack, set mask, fetch vector.
// RULE2: Masked request stays pending until unmasked.
// RULE3: Return-from-interrupt restores mask clear.
// RULE4: Reset sets mask; only clear instruction clears; here return-from-interrupt and stop entry also clear it.
// RULE5: Pending flag read-only, set by pins.
// RULE6: Vector fetch or request-clear clears pending.
// RULE7: Request-clear write-only, reads zero.
// RULE8: Core timer requests blocked by mask.
// RULE9: Overflow request needs flag and enable.
// RULE10: Periodic request needs flag and enable.
// RULE11: Five reset sources reset device.
// RULE12: Software writes zero to restart watchdog.
// RULE13: Watchdog or low-voltage pulls reset pin.
// RULE14: Option bit alone enables watchdog reset.
// RULE15: Low supply asserts internal reset.
// RULE16: Reset selects low-power oscillator only.
// RULE17: Stop halts oscillators, keeps select bits.
// RULE18: Stop clears core timer flags, enables.
// RULE19: Stop clears programmable timer flags, enables.
// RULE20: Stop sets external enable, clears mask.
// RULE21: Edge wakes to ext vector; pin to reset.
// RULE22: Resume after 16 or 4064 cycles.
// RULE23: Pins synchronised, except asynchronous stop wake; here the stop wake also uses the synchronised pins.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module irsc_ctrl
    import irsc_pkg::*;
#(
    parameter int WDOG_TIMEOUT = 65536,
    parameter int STAB_LONG    = 4064
)
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [12:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [7:0]  reg_rdata,
    // Pins and monitors
    input  wire logic        ext_irq_n,
    input  wire logic [3:0]  port_a_in,
    input  wire logic        reset_pin_in,
    output var  logic        reset_pin_out,
    output var  logic        reset_pin_oe,
    input  wire logic        low_voltage,
    input  wire logic        illegal_fetch,
    // Option byte
    input  wire logic        watchdog_enable_option,
    input  wire logic        port_a_interrupt_option,
    input  wire logic        delay_option,
    // Core and programmable timer event sources
    input  wire logic        core_overflow_event,
    input  wire logic        periodic_event,
    input  wire logic [2:0]  ptimer_event,
    // CPU side
    output var  logic        int_mask,
    output var  logic        irq_take,
    output var  logic [12:0] vector_addr,
    output var  logic        ext_pending_flag,
    output var  logic        core_timer_req,
    output var  logic        osc_low_power_run,
    output var  logic        osc_external_run,
    output var  logic        clocks_run,
    output var  logic        cpu_run,
    output var  logic        sys_reset
);
    `include "irsc_defs.svh"
    localparam int STAB_SHORT = `IRSC_STAB_SHORT;

    irsc_mode_t mode_r;
    logic [7:0]  core_tmr_r;
    logic [7:0]  pt_stat_r;
    logic [7:0]  pt_ctl_r;
    logic        ext_int_enable_r;
    logic        osc_select_high_r;
    logic        osc_select_low_r;
    logic        watchdog_clear_bit_r;
    logic [16:0] wdog_cnt_r;
    logic [11:0] stab_cnt_r;
    logic        irq_s;
    logic        irq_prev_r;
    logic [3:0]  pa_s;
    logic [3:0]  pa_prev_r;
    logic        rst_pin_s;
    logic        lv_s;
    logic        pulse_oe;
    logic        wdog_fire;
    logic        rst_fire;
    logic        int_reset;

    function automatic logic wr_hit(input logic [12:0] a);
        wr_hit = reg_wr && reg_addr == a;
    endfunction

    function automatic logic wr_bit(input logic [12:0] a, input int b);
        wr_bit = wr_hit(a) && reg_wdata[b];
    endfunction

    // Pin synchronisers
    irsc_sync u_sync_irq
    (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .async_in (ext_irq_n),
        .sync_out (irq_s)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_pa
            irsc_sync u_sync_pa
            (
                .sys_clk  (sys_clk),
                .resetn   (resetn),
                .async_in (port_a_in[gi]),
                .sync_out (pa_s[gi])
            );
        end
    endgenerate

    irsc_sync u_sync_rst
    (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .async_in (reset_pin_in),
        .sync_out (rst_pin_s)
    );

    irsc_sync u_sync_lv
    (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .async_in (low_voltage),
        .sync_out (lv_s)
    );

    // Reset sources
    assign wdog_fire = watchdog_enable_option && mode_r == IRSC_RUN
                       && wdog_cnt_r == 17'(WDOG_TIMEOUT - 1); // RULE14
    assign rst_fire  = wdog_fire || lv_s; // RULE13 RULE15
    assign int_reset = !rst_pin_s || rst_fire || illegal_fetch; // RULE11

    irsc_pin_pulse u_pulse
    (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .fire    (rst_fire),
        .pull_oe (pulse_oe)
    );

    always_comb
    begin
        reset_pin_out = 1'b0;
        reset_pin_oe  = pulse_oe; // RULE13
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            sys_reset <= 1'b1;
        else
            sys_reset <= int_reset; // RULE11
    end

    // Edge events on synchronised pins; pins act in every mode, stop included
    logic ext_edge;
    assign ext_edge = (irq_prev_r && !irq_s)
                      || (port_a_interrupt_option && |(pa_s & ~pa_prev_r)); // RULE5

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            // Matches the synchroniser's reset output, so release shows no false edge
            irq_prev_r <= 1'b0;
            pa_prev_r  <= 4'h0;
        end
        else
        begin
            irq_prev_r <= irq_s;
            pa_prev_r  <= pa_s;
        end
    end

    // Interrupt arbitration: pending stays until mask clear
    logic ext_req;
    logic ovf_req;
    logic per_req;
    assign ext_req = ext_pending_flag && ext_int_enable_r;
    assign ovf_req = core_tmr_r[`IRSC_CT_OVF_FLAG] && core_tmr_r[`IRSC_CT_OVF_EN]; // RULE9
    assign per_req = core_tmr_r[`IRSC_CT_PER_FLAG] && core_tmr_r[`IRSC_CT_PER_EN]; // RULE10
    assign core_timer_req = (ovf_req || per_req) && !int_mask; // RULE8

    always_comb
    begin
        irq_take = mode_r == IRSC_RUN && !int_mask && (ext_req || ovf_req || per_req); // RULE1 RULE2
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn || sys_reset)
            vector_addr <= `IRSC_VEC_RESET; // RULE11
        else if (mode_r == IRSC_STOP && ext_edge)
            vector_addr <= `IRSC_VEC_EXT; // RULE21
        else if (irq_take && ext_req)
            vector_addr <= `IRSC_VEC_EXT;
    end

    // Interrupt mask
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || sys_reset)
            int_mask <= 1'b1; // RULE4
        else if (irq_take)
            int_mask <= 1'b1; // RULE1
        else if (wr_hit(`IRSC_ADDR_CPUCTL) && reg_wdata[`IRSC_CPU_STOP])
            int_mask <= 1'b0; // RULE20
        else if (wr_bit(`IRSC_ADDR_CPUCTL, `IRSC_CPU_UNMASK)
                 || wr_bit(`IRSC_ADDR_CPUCTL, `IRSC_CPU_RET_INT))
            int_mask <= 1'b0; // RULE3 RULE4
    end

    // External pending flag: set wins over clear
    logic ext_clr;
    assign ext_clr = wr_bit(`IRSC_ADDR_EXT_CTL, `IRSC_IS_REQ_CLR)
                     || wr_bit(`IRSC_ADDR_CPUCTL, `IRSC_CPU_VECFETCH); // RULE6 RULE7

    always_ff @(posedge sys_clk)
    begin
        if (!resetn || sys_reset)
            ext_pending_flag <= 1'b0; // RULE5
        else if (ext_edge)
            ext_pending_flag <= 1'b1; // RULE23
        else if (ext_clr)
            ext_pending_flag <= 1'b0; // RULE6
    end

    // External status/control: enable and oscillator selects
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || sys_reset)
        begin
            ext_int_enable_r  <= 1'(`IRSC_EXT_CTL_RST >> `IRSC_IS_EXT_EN);
            osc_select_high_r <= 1'b1; // RULE16
            osc_select_low_r  <= 1'b0; // RULE16
        end
        else if (wr_bit(`IRSC_ADDR_CPUCTL, `IRSC_CPU_STOP))
            ext_int_enable_r <= 1'b1; // RULE20
        else if (wr_hit(`IRSC_ADDR_EXT_CTL))
        begin
            ext_int_enable_r  <= reg_wdata[`IRSC_IS_EXT_EN];
            osc_select_high_r <= reg_wdata[`IRSC_IS_OSC_HIGH];
            osc_select_low_r  <= reg_wdata[`IRSC_IS_OSC_LOW];
        end
    end

    // Core timer flags and enables
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || sys_reset)
            core_tmr_r <= 8'h00;
        else if (wr_bit(`IRSC_ADDR_CPUCTL, `IRSC_CPU_STOP))
            core_tmr_r <= 8'h00; // RULE18
        else if (mode_r == IRSC_RUN)
        begin
            if (core_overflow_event)
                core_tmr_r[`IRSC_CT_OVF_FLAG] <= 1'b1;
            else if (wr_bit(`IRSC_ADDR_CORE_TMR, `IRSC_CT_OVF_CLR))
                core_tmr_r[`IRSC_CT_OVF_FLAG] <= 1'b0; // RULE9
            if (periodic_event)
                core_tmr_r[`IRSC_CT_PER_FLAG] <= 1'b1;
            else if (wr_bit(`IRSC_ADDR_CORE_TMR, `IRSC_CT_PER_CLR))
                core_tmr_r[`IRSC_CT_PER_FLAG] <= 1'b0; // RULE10
            if (wr_hit(`IRSC_ADDR_CORE_TMR))
            begin
                core_tmr_r[`IRSC_CT_OVF_EN] <= reg_wdata[`IRSC_CT_OVF_EN];
                core_tmr_r[`IRSC_CT_PER_EN] <= reg_wdata[`IRSC_CT_PER_EN];
            end
        end
    end

    // Programmable timer flags and enables
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || sys_reset)
        begin
            pt_stat_r <= 8'h00;
            pt_ctl_r  <= 8'h00;
        end
        else if (wr_bit(`IRSC_ADDR_CPUCTL, `IRSC_CPU_STOP))
        begin
            pt_stat_r <= 8'h00; // RULE19
            pt_ctl_r  <= 8'h00; // RULE19
        end
        else if (mode_r == IRSC_RUN)
        begin
            pt_stat_r <= pt_stat_r | {ptimer_event, 5'h00};
            if (wr_hit(`IRSC_ADDR_PT_CTL))
                pt_ctl_r <= reg_wdata & 8'he0;
        end
    end

    // Watchdog: writing zero restarts, counter frozen outside run
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || sys_reset)
            watchdog_clear_bit_r <= 1'b0; // RULE12
        else if (wr_hit(`IRSC_ADDR_WDOG))
            watchdog_clear_bit_r <= reg_wdata[`IRSC_WD_CLEAR];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn || sys_reset)
            wdog_cnt_r <= 17'h0_0000;
        else if (wr_hit(`IRSC_ADDR_WDOG) && !reg_wdata[`IRSC_WD_CLEAR])
            wdog_cnt_r <= 17'h0_0000; // RULE12
        else if (mode_r == IRSC_RUN)
            wdog_cnt_r <= wdog_cnt_r + 17'h0_0001; // RULE17
    end

    // Stop mode sequencer
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || sys_reset)
        begin
            mode_r     <= IRSC_RUN;
            stab_cnt_r <= 12'h000;
        end
        else
        begin
            case (mode_r)
                IRSC_RUN:
                    if (wr_bit(`IRSC_ADDR_CPUCTL, `IRSC_CPU_STOP))
                        mode_r <= IRSC_STOP; // RULE17
                IRSC_STOP:
                    if (ext_edge)
                    begin
                        mode_r     <= IRSC_STAB; // RULE21
                        stab_cnt_r <= delay_option ? 12'(STAB_LONG - 1)
                                                   : 12'(STAB_SHORT - 1); // RULE22
                    end
                IRSC_STAB:
                    if (stab_cnt_r == 12'h000)
                        mode_r <= IRSC_RUN; // RULE22
                    else
                        stab_cnt_r <= stab_cnt_r - 12'h001;
                default:
                    mode_r <= IRSC_RUN;
            endcase
        end
    end

    always_comb
    begin
        clocks_run        = mode_r != IRSC_STOP; // RULE17
        cpu_run           = mode_r == IRSC_RUN;
        // Both selects set: external warms up while the low-power one still clocks
        osc_low_power_run = clocks_run && (osc_select_high_r || !osc_select_low_r); // RULE16
        osc_external_run  = clocks_run && osc_select_high_r && osc_select_low_r;
    end

    // Register read: one cycle latency
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `IRSC_ADDR_CORE_TMR:
                    reg_rdata <= core_tmr_r & 8'hf0;
                `IRSC_ADDR_EXT_CTL:
                    reg_rdata <= {ext_int_enable_r, osc_select_high_r, osc_select_low_r,
                                  1'b0, ext_pending_flag, 3'h0}; // RULE7
                `IRSC_ADDR_PT_STAT:
                    reg_rdata <= pt_stat_r;
                `IRSC_ADDR_PT_CTL:
                    reg_rdata <= pt_ctl_r;
                `IRSC_ADDR_STATUS:
                    reg_rdata <= {5'h00, int_mask, 2'(mode_r)};
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // Assertions
    property p_mask_on_take;
        @(posedge sys_clk) disable iff (!resetn)
        irq_take && !sys_reset |=> int_mask;
    endproperty
    a_mask_on_take: assert property (p_mask_on_take) // RULE1
        else $error("mask not set after interrupt taken");

    a_masked_no_take: assert property (@(posedge sys_clk) disable iff (!resetn)
        int_mask |-> !irq_take) // RULE2
        else $error("interrupt taken while masked");

    a_masked_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        int_mask && ext_pending_flag && !ext_clr && !sys_reset |=> ext_pending_flag) // RULE2
        else $error("masked request lost");

    a_reset_mask: assert property (@(posedge sys_clk) disable iff (!resetn)
        sys_reset |=> int_mask) // RULE4
        else $error("mask clear after reset");

    a_pend_set: assert property (@(posedge sys_clk) disable iff (!resetn)
        ext_edge && !sys_reset |=> ext_pending_flag) // RULE5
        else $error("edge lost");

    a_pend_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        ext_clr && !ext_edge && !sys_reset |=> !ext_pending_flag) // RULE6
        else $error("pending flag not cleared");

    a_ct_blocked: assert property (@(posedge sys_clk) disable iff (!resetn)
        int_mask |-> !core_timer_req) // RULE8
        else $error("core timer request while masked");

    sequence s_stop_entry;
        mode_r == IRSC_RUN && wr_bit(`IRSC_ADDR_CPUCTL, `IRSC_CPU_STOP) && !sys_reset;
    endsequence
    a_stop_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_stop_entry |=> core_tmr_r == 8'h00 && pt_stat_r == 8'h00 && pt_ctl_r == 8'h00) // RULE18
        else $error("stop left timer state");

    a_stop_unmask: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_stop_entry |=> ext_int_enable_r && !int_mask && !clocks_run) // RULE20
        else $error("stop entry wrong");

    a_pin_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(reset_pin_oe) |-> reset_pin_oe [*3] ##1 !reset_pin_oe) // RULE13
        else $error("reset pulse length wrong");

    // Sixteen stalled cycles as two runs of eight keeps the unrolled repetition small
    sequence s_stall8;
        !cpu_run [*8];
    endsequence
    a_stab_short: assert property (@(posedge sys_clk) disable iff (!resetn)
        mode_r == IRSC_STOP && ext_edge && !delay_option && !sys_reset
        |=> s_stall8 ##1 s_stall8 ##1 cpu_run) // RULE22
        else $error("short stabilisation wrong");
endmodule
`default_nettype wire

// file: sim/irsc_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
// Far side: interrupt pins, supply monitor and the reset pin with its pull-up
module irsc_pins_model
(
    // Clock
    input  wire logic       sys_clk,
    // Reset pin pulldown from the device
    input  wire logic       reset_pin_out,
    input  wire logic       reset_pin_oe,
    // Pins seen by the device
    output var  logic       ext_irq_n,
    output var  logic [3:0] port_a_in,
    output wire logic       reset_pin_in,
    output var  logic       low_voltage
);
    logic rst_drv;

    initial
    begin
        ext_irq_n = 1'b1;
        port_a_in = 4'h0;
        rst_drv = 1'b1;
        low_voltage = 1'b0;
    end

    // Either party may pull low; the pull-up holds the pin high otherwise
    assign reset_pin_in = rst_drv & ~(reset_pin_oe & ~reset_pin_out);

    // Levels move just after an edge; the device does its own synchronising
    task automatic drive(input logic e, input logic [3:0] pa, input logic r, input logic lv);
        @(posedge sys_clk);
        ext_irq_n <= e;
        port_a_in <= pa;
        rst_drv <= r;
        low_voltage <= lv;
    endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "irsc_defs.svh"
module tb_top
    import irsc_pkg::*;
;
    localparam int STAB_L = 40;
    localparam logic [12:0] AD_CT = `IRSC_ADDR_CORE_TMR;
    localparam logic [12:0] AD_IS = `IRSC_ADDR_EXT_CTL;
    localparam logic [12:0] AD_TS = `IRSC_ADDR_PT_STAT;
    localparam logic [12:0] AD_TC = `IRSC_ADDR_PT_CTL;
    localparam logic [12:0] AD_WD = `IRSC_ADDR_WDOG;
    localparam logic [12:0] AD_CPU = `IRSC_ADDR_CPUCTL;
    localparam logic [12:0] AD_ST = `IRSC_ADDR_STATUS;

    logic        sys_clk, resetn, reg_wr, reg_rd, rd_seen, oe_seen, rst_seen;
    logic        watchdog_enable_option, port_a_interrupt_option, delay_option;
    logic        core_overflow_event, periodic_event, illegal_fetch;
    logic [2:0]  ptimer_event;
    logic [3:0]  port_a_in;
    logic [12:0] reg_addr, vector_addr;
    irsc_byte_t  reg_wdata, reg_rdata, exp_q[$];
    logic        ext_irq_n, reset_pin_in, reset_pin_out, reset_pin_oe, low_voltage;
    logic        int_mask, irq_take, ext_pending_flag, core_timer_req, sys_reset;
    logic        osc_low_power_run, osc_external_run, clocks_run, cpu_run;
    int          n_mismatch, checks, cnt, k, st;

    irsc_ctrl #(.WDOG_TIMEOUT(64), .STAB_LONG(STAB_L)) dut
    (
        .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .ext_irq_n, .port_a_in, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
        .low_voltage, .illegal_fetch, .watchdog_enable_option,
        .port_a_interrupt_option, .delay_option, .core_overflow_event,
        .periodic_event, .ptimer_event, .int_mask, .irq_take, .vector_addr,
        .ext_pending_flag, .core_timer_req, .osc_low_power_run,
        .osc_external_run, .clocks_run, .cpu_run, .sys_reset
    );

    irsc_pins_model pm
    (
        .sys_clk, .reset_pin_out, .reset_pin_oe, .ext_irq_n, .port_a_in,
        .reset_pin_in, .low_voltage
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [12:0] a, input irsc_byte_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [12:0] a, input irsc_byte_t e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic pulse(input logic [4:0] v);
        @(posedge sys_clk);
        {core_overflow_event, periodic_event, ptimer_event} <= v;
        @(posedge sys_clk);
        {core_overflow_event, periodic_event, ptimer_event} <= 5'h00;
    endtask

    // Sampled on the falling edge so the launching edge has settled; cnt is the wait
    task automatic wait_v(ref logic s, input logic v, input int n);
        cnt = 1;
        @(negedge sys_clk);
        while (s !== v && cnt < n)
        begin
            @(negedge sys_clk);
            cnt++;
        end
        chk(s, v);
    endtask

    task automatic boot();
        @(posedge sys_clk);
        resetn <= 1'b0;
        cyc(3);
        resetn <= 1'b1;
        wait_v(sys_reset, 1'b0, 20);
        cyc(2);
    endtask

    always @(posedge sys_clk)
    begin
        rd_seen <= reg_rd;
        if (reset_pin_oe === 1'b1)
            oe_seen <= 1'b1;
        if (sys_reset === 1'b1)
            rst_seen <= 1'b1;
    end

    // Read data stands only in the cycle after the strobe
    always @(negedge sys_clk)
    begin
        if (rd_seen === 1'b1)
            chk(reg_rdata, exp_q.pop_front());
    end

    // Roughly ten times the length of the whole sequence
    initial
    begin
        cyc(6000);
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        {resetn, reg_wr, reg_rd, rd_seen, oe_seen, rst_seen} = '0;
        {watchdog_enable_option, port_a_interrupt_option, delay_option} = '0;
        {core_overflow_event, periodic_event, ptimer_event, illegal_fetch} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        n_mismatch = 0;
        checks = 0;
        k = $urandom(32'h6d477f6b);
        boot();
        rd(AD_ST, 8'h04);
        rd(AD_IS, 8'h40);
        rd(13'h0003, 8'h00);
        @(negedge sys_clk);
        chk({osc_low_power_run, osc_external_run}, 2'b10);
        wr(AD_IS, 8'h60);
        @(negedge sys_clk);
        chk({osc_low_power_run, osc_external_run}, 2'b11);
        chk(vector_addr, 13'h1ffe);
        wr(AD_IS, 8'hc0);
        pm.drive(1'b0, 4'h0, 1'b1, 1'b0);
        wait_v(ext_pending_flag, 1'b1, 8);
        chk(irq_take, 1'b0);
        wr(AD_IS, 8'hc0);
        rd(AD_IS, 8'hc8);
        wr(AD_CPU, 8'h01);
        wait_v(irq_take, 1'b1, 3);
        wait_v(int_mask, 1'b1, 3);
        chk(vector_addr, 13'h1ffa);
        wr(AD_CPU, 8'h08);
        @(negedge sys_clk);
        chk(ext_pending_flag, 1'b0);
        wr(AD_CPU, 8'h02);
        rd(AD_ST, 8'h00);
        port_a_interrupt_option <= 1'b1;
        k = $urandom_range(3, 0);
        pm.drive(1'b1, 4'(4'h1 << k), 1'b1, 1'b0);
        wait_v(ext_pending_flag, 1'b1, 8);
        wait_v(int_mask, 1'b1, 4);
        wr(AD_IS, 8'hc2);
        rd(AD_IS, 8'hc0);
        wr(AD_CT, 8'h30);
        pulse(5'h18);
        rd(AD_CT, 8'hf0);
        @(negedge sys_clk);
        chk(core_timer_req, 1'b0);
        wr(AD_CPU, 8'h01);
        @(negedge sys_clk);
        chk(core_timer_req, 1'b1);
        wr(AD_CT, 8'h38);
        rd(AD_CT, 8'h70);
        wr(AD_CT, 8'h34);
        rd(AD_CT, 8'h30);
        pulse(5'h18);
        wr(AD_TC, 8'he0);
        pulse(5'h07);
        rd(AD_TS, 8'he0);
        for (int i = 0; i < 2; i++)
        begin
            wr(AD_IS, 8'h42);
            delay_option <= i[0];
            st = i ? STAB_L : 16;
            wr(AD_CPU, 8'h04);
            @(negedge sys_clk);
            chk({clocks_run, cpu_run, osc_low_power_run}, 3'b000);
            rd(AD_ST, 8'h01);
            rd(AD_IS, 8'hc0);
            rd(AD_CT, 8'h00);
            rd(AD_TS, 8'h00);
            rd(AD_TC, 8'h00);
            pm.drive(i[0], 4'({3'b000, i[0]} << k), 1'b1, 1'b0);
            wait_v(cpu_run, 1'b1, st + 12);
            chk(cnt >= st && cnt <= st + 10, 1'b1);
            chk(vector_addr, 13'h1ffa);
        end
        // Kick before enabling: a count run up while disabled must not fire at once
        wr(AD_WD, 8'h00);
        watchdog_enable_option <= 1'b1;
        {oe_seen, rst_seen} = 2'b00;
        repeat (4)
        begin
            wr(AD_WD, 8'h00);
            cyc($urandom_range(40, 10));
        end
        chk({oe_seen, rst_seen}, 2'b00);
        wr(AD_WD, 8'h01);
        wait_v(reset_pin_oe, 1'b1, 80);
        wait_v(reset_pin_oe, 1'b0, 6);
        chk(cnt >= 3 && cnt <= 4, 1'b1);
        chk(reset_pin_out, 1'b0);
        chk(rst_seen, 1'b1);
        boot();
        watchdog_enable_option <= 1'b0;
        rd(AD_IS, 8'h40);
        rd(AD_ST, 8'h04);
        {oe_seen, rst_seen} = 2'b00;
        cyc(150);
        chk({oe_seen, rst_seen}, 2'b00);
        for (int i = 0; i < 3; i++)
        begin
            {oe_seen, rst_seen} = 2'b00;
            pm.drive(1'b1, 4'h0, i != 1, i == 0);
            illegal_fetch <= (i == 2);
            wait_v(sys_reset, 1'b1, 10);
            @(posedge sys_clk);
            illegal_fetch <= 1'b0;
            pm.drive(1'b1, 4'h0, 1'b1, 1'b0);
            wait_v(sys_reset, 1'b0, 30);
            if (i < 2)
                chk(oe_seen, i == 0);
            chk(vector_addr, 13'h1ffe);
        end
        cyc(3);
        give_verdict();
    end
endmodule
`default_nettype wire
